// ==== src/hie_top.sv ====
// Host interrupt enable stage with status latch, list masks and AHB-Lite slave
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "hie_defs.svh"

module hie_top
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        dual_role_latch_event,
	input  wire logic [31:0] iso_done_map,
	input  wire logic [31:0] int_done_map,
	input  wire logic [31:0] async_list_done_map,
	input  wire logic        clock_stable_event,
	input  wire logic        suspend_entry_event,
	input  wire logic        dma_end_event,
	input  wire logic        frame_start_event,
	output logic             irq
);
	import hie_pkg::*;

	// ********************************
	// State
	// ********************************
	// Bus phase, captured address, read data, registers and line in one word;
	// a single register stage keeps the reset and the update in one place
	// and leaves no state outside the struct
	typedef struct packed {
		hie_phase_t  phase;
		logic        wr;
		logic [11:0] addr;
		logic [31:0] rdata;
		logic [31:0] enable;
		logic [31:0] status;
		logic [31:0] iso_or;
		logic [31:0] int_or;
		logic [31:0] atl_or;
		logic [31:0] iso_and;
		logic [31:0] int_and;
		logic [31:0] atl_and;
		logic        irq;
	} hie_state_t;

	hie_state_t  st;
	hie_state_t  next_st;
	logic [31:0] events;
	logic [11:0] bus_addr;
	logic        take;

	// One matcher per descriptor list, each with its own pair of masks
	hie_match_if iso_m ();
	hie_match_if int_m ();
	hie_match_if atl_m ();

	// ********************************
	// Descriptor list matching
	// ********************************
	assign iso_m.done_map = iso_done_map;
	assign iso_m.or_mask  = st.iso_or;
	assign iso_m.and_mask = st.iso_and;
	assign int_m.done_map = int_done_map;
	assign int_m.or_mask  = st.int_or;
	assign int_m.and_mask = st.int_and;
	assign atl_m.done_map = async_list_done_map;
	assign atl_m.or_mask  = st.atl_or;
	assign atl_m.and_mask = st.atl_and;

	hie_match u_iso (.m(iso_m));
	hie_match u_int (.m(int_m));
	hie_match u_atl (.m(atl_m));

	// Event vector in status-bit positions; inputs may be levels or
	// one-cycle pulses, since any high cycle sets the sticky status bit
	// and the bit then stays until software clears it
	always_comb
	begin
		events                   = 32'h0000_0000;
		events[`HIE_BIT_OTG]     = dual_role_latch_event;
		events[`HIE_BIT_ISO]     = iso_m.hit;
		events[`HIE_BIT_ATL]     = atl_m.hit;
		events[`HIE_BIT_INT]     = int_m.hit;
		events[`HIE_BIT_CLK]     = clock_stable_event;
		events[`HIE_BIT_SUSP]    = suspend_entry_event;
		events[`HIE_BIT_DMA]     = dma_end_event;
		events[`HIE_BIT_FRAME]   = frame_start_event;
	end

	// ********************************
	// Address phase
	// ********************************
	// A transfer starts on NONSEQ or SEQ with the bus ready; IDLE and BUSY
	// never reach the registers
	assign take = hsel & hready & htrans[1];

	// Word address; hsize is not decoded, as every register is one whole word
	// and the block repeats every 4 KB
	assign bus_addr = {haddr[11:2], 2'b00};

	// ********************************
	// Next state
	// ********************************
	always_comb
	begin
		next_st       = st;
		next_st.phase = take ? HIE_PH_DATA : HIE_PH_IDLE;
		next_st.wr    = take & hwrite;
		if (take)
		begin
			next_st.addr = bus_addr;
		end

		// Register writes land at the edge that ends their data phase
		if (st.phase == HIE_PH_DATA && st.wr)
		begin
			unique case (st.addr)
				// Writing one clears a status bit
				`HIE_OFS_STATUS:  next_st.status  = st.status & ~hwdata;
				// Reserved bits hold zero whatever software writes
				`HIE_OFS_ENABLE:  next_st.enable  = hwdata & `HIE_EN_MASK;
				`HIE_OFS_ISO_OR:  next_st.iso_or  = hwdata;
				`HIE_OFS_INT_OR:  next_st.int_or  = hwdata;
				`HIE_OFS_ATL_OR:  next_st.atl_or  = hwdata;
				`HIE_OFS_ISO_AND: next_st.iso_and = hwdata;
				`HIE_OFS_INT_AND: next_st.int_and = hwdata;
				`HIE_OFS_ATL_AND: next_st.atl_and = hwdata;
				default:          next_st.status  = st.status; // Ignored write
			endcase
		end

		// Status sticks until cleared; an event in the clearing cycle wins
		next_st.status = (next_st.status | events) & `HIE_EN_MASK;

		// Read data is picked from the values this edge stores, so a read right
		// behind a write sees the new word; the wider mux is the price of a
		// registered hrdata
		next_st.rdata = 32'h0000_0000;
		if (take && !hwrite)
		begin
			unique case (bus_addr)
				`HIE_OFS_STATUS:  next_st.rdata = next_st.status;
				`HIE_OFS_ENABLE:  next_st.rdata = next_st.enable;
				`HIE_OFS_ISO_OR:  next_st.rdata = next_st.iso_or;
				`HIE_OFS_INT_OR:  next_st.rdata = next_st.int_or;
				`HIE_OFS_ATL_OR:  next_st.rdata = next_st.atl_or;
				`HIE_OFS_ISO_AND: next_st.rdata = next_st.iso_and;
				`HIE_OFS_INT_AND: next_st.rdata = next_st.int_and;
				`HIE_OFS_ATL_AND: next_st.rdata = next_st.atl_and;
				default:          next_st.rdata = 32'h0000_0000; // Unmapped reads zero
			endcase
		end

		// Line from the stored status gated bit by bit with the stored enables
		next_st.irq = |(next_st.status & next_st.enable);
	end

	// ********************************
	// Registers
	// ********************************
	// One register stage holds the whole state; reset is synchronous,
	// so the clock must run while it is held
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			// Every register clears, which also drops the line
			st         <= '0;
			st.phase   <= HIE_PH_IDLE;
			st.enable  <= `HIE_RST_ENABLE;
			st.status  <= `HIE_RST_STATUS;
			st.iso_or  <= `HIE_RST_MASK;
			st.int_or  <= `HIE_RST_MASK;
			st.atl_or  <= `HIE_RST_MASK;
			st.iso_and <= `HIE_RST_MASK;
			st.int_and <= `HIE_RST_MASK;
			st.atl_and <= `HIE_RST_MASK;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	// Every register answers at once, so the slave never stretches a
	// data phase and never signals an error
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Read data is zero outside the data phase of a read
	assign hrdata    = st.rdata;

	// Registered line: no glitch from the event inputs reaches the host,
	// at the cost of one cycle of latency
	assign irq       = st.irq;

endmodule : hie_top

`default_nettype wire

// ==== src/hie_defs.svh ====
// Register offsets, field positions and reset values of the host interrupt enable block
`ifndef HIE_DEFS_SVH
`define HIE_DEFS_SVH

// ********************************
// Register byte offsets
// ********************************
`define HIE_OFS_STATUS      12'h310
`define HIE_OFS_ENABLE      12'h314
`define HIE_OFS_ISO_OR      12'h318
`define HIE_OFS_INT_OR      12'h31c
`define HIE_OFS_ATL_OR      12'h320
`define HIE_OFS_ISO_AND     12'h324
`define HIE_OFS_INT_AND     12'h328
`define HIE_OFS_ATL_AND     12'h32c

// ********************************
// Enable and status bit positions
// ********************************
`define HIE_BIT_FRAME       1
`define HIE_BIT_DMA         3
`define HIE_BIT_SUSP        5
`define HIE_BIT_CLK         6
`define HIE_BIT_INT         7
`define HIE_BIT_ATL         8
`define HIE_BIT_ISO         9
`define HIE_BIT_OTG         10

// Writable bits of the enable and status registers
`define HIE_EN_MASK         32'h0000_07ea

// ********************************
// Reset values
// ********************************
`define HIE_RST_ENABLE      32'h0000_0000
`define HIE_RST_MASK        32'h0000_0000
`define HIE_RST_STATUS      32'h0000_0000

`endif

// ==== src/hie_pkg.sv ====
// Types shared by the host interrupt enable block
package hie_pkg;

	// One descriptor list: done map in, matching event out
	typedef enum logic [1:0] {
		HIE_LIST_ISO,
		HIE_LIST_INT,
		HIE_LIST_ATL
	} hie_list_t;

	// Bus slave data phase state
	typedef enum logic {
		HIE_PH_IDLE,
		HIE_PH_DATA
	} hie_phase_t;

endpackage : hie_pkg

// ==== src/hie_match_if.sv ====
// Carrier between the register file and the descriptor match logic
`timescale 1ns/100ps
`default_nettype none

interface hie_match_if;
	logic [31:0] done_map;
	logic [31:0] or_mask;
	logic [31:0] and_mask;
	logic        hit;

	modport top (output done_map, output or_mask, output and_mask, input hit);
	modport match (input done_map, input or_mask, input and_mask, output hit);
endinterface : hie_match_if

`default_nettype wire

// ==== src/hie_match.sv ====
// Descriptor completion matcher for one list, against its OR and AND masks
`timescale 1ns/100ps
`default_nettype none

module hie_match
(
	hie_match_if.match m
);
	import hie_pkg::*;

	logic [31:0] done_and;

	// Per-descriptor AND term: a cleared mask bit never blocks
	genvar g;
	generate
		for (g = 0; g < 32; g++)
		begin : g_and
			assign done_and[g] = m.done_map[g] | ~m.and_mask[g];
		end
	endgenerate

	// Any OR-listed descriptor done, or all AND-listed ones done
	assign m.hit = (|(m.done_map & m.or_mask))
		| ((|m.and_mask) & (&done_and));

endmodule : hie_match

`default_nettype wire

// ==== tb/hie_assertions.sv ====
// Port-level checker of the host interrupt enable block
`timescale 1ns/100ps
`default_nettype none
`include "hie_defs.svh"
module hie_chk
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        dual_role_latch_event,
	input wire logic [31:0] iso_done_map,
	input wire logic [31:0] int_done_map,
	input wire logic [31:0] async_list_done_map,
	input wire logic        clock_stable_event,
	input wire logic        suspend_entry_event,
	input wire logic        dma_end_event,
	input wire logic        frame_start_event,
	input wire logic        irq
);
	// ****
	// Enable shadow
	// ****
	logic [31:0] en;
	logic        wr;
	logic        wen;
	wire         take = hsel && hready && htrans[1];
	wire         hit = |{iso_done_map, int_done_map, async_list_done_map};
	wire         ev = dual_role_latch_event || clock_stable_event || suspend_entry_event;
	wire         ev2 = dma_end_event || frame_start_event || hit;
	// Follows writes so the gating can be judged from the ports alone
	always_ff @(posedge sys_clk)
	begin
		wr <= !rst && take && hwrite;
		wen <= !rst && take && hwrite && haddr[11:0] == 12'h314;
		en <= rst ? 32'h0 : wen ? hwdata & `HIE_EN_MASK : en;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence rd_take;
		take && !hwrite && haddr[11:0] == 12'h314;
	endsequence
	// A gate may only stay shut if its enable bit is clear
	property gate(e, b);
		e |=> irq || !en[b];
	endproperty
	otg_gate_a: assert property (gate(dual_role_latch_event, 10)) else $error("otg gate");
	clk_gate_a: assert property (gate(clock_stable_event, 6)) else $error("clk gate");
	susp_gate_a: assert property (gate(suspend_entry_event, 5)) else $error("susp gate");
	dma_gate_a: assert property (gate(dma_end_event, 3)) else $error("dma gate");
	sof_gate_a: assert property (gate(frame_start_event, 1)) else $error("sof gate");
	irq_quiet_a: assert property (en == 32'h0 |-> !irq) else $error("irq not gated");
	enable_read_a: assert property (rd_take |=> hrdata == en) else $error("enable read");
	irq_cause_a: assert property ($rose(irq) |-> $past(ev || ev2 || wr)) else $error("no cause");
	// The slave never waits and always answers OKAY
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus response");
endmodule : hie_chk
bind hie_top hie_chk u_chk (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench of the host interrupt enable block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [4:0]  evs;
	logic [31:0] dm [3];
	int          fails, compares;
	int          ep [5] = '{10, 6, 5, 3, 1};
	int          lb [3] = '{9, 7, 8};
	assign hready = hreadyout;
	hie_top dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .dual_role_latch_event(evs[0]),
		.iso_done_map(dm[0]), .int_done_map(dm[1]), .async_list_done_map(dm[2]),
		.clock_stable_event(evs[1]), .suspend_entry_event(evs[2]),
		.dma_end_event(evs[3]), .frame_start_event(evs[4]), .irq(irq));
	// Clock, 10 ns period
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] e, s);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic chk_irq(input string n, input logic e);
		compares++;
		if (irq !== e)
		begin
			fails++;
			$display("[FAIL] %s exp %b got %b", n, e, irq);
		end
	endtask : chk_irq
	// Values are kept before the edge, as the bus samples them there
	task automatic hwait;
		logic r;
		do
		begin
			@(negedge sys_clk);
			q = hrdata;
			r = hready;
			@(posedge sys_clk);
		end while (r !== 1'b1);
	endtask : hwait
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hwait;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hwait;
		@(negedge sys_clk);
	endtask : bus
	task automatic pulse(input logic [4:0] v);
		@(posedge sys_clk);
		evs <= v;
		@(posedge sys_clk);
		evs <= 5'h0;
		@(negedge sys_clk);
	endtask : pulse
	task automatic setdm(input int k, input logic [31:0] v);
		@(posedge sys_clk);
		dm[k] <= v;
		@(posedge sys_clk);
		@(negedge sys_clk);
	endtask : setdm
	task automatic t_regs;
		bus(1'b0, 32'h0000_0314, 32'h0000_0000);
		chk("enable reset", 32'h0000_0000, q);
		bus(1'b0, 32'h0000_0400, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, q);
		bus(1'b1, 32'h0000_0314, 32'h0000_07ea);
		bus(1'b0, 32'h0000_0314, 32'h0000_0000);
		chk("enable all", 32'h0000_07ea, q);
	endtask : t_regs
	task automatic t_events;
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b1, 32'h0000_0314, 32'h0000_0000);
			pulse(5'h01 << i);
			chk_irq("irq masked", 1'b0);
			bus(1'b1, 32'h0000_0314, 32'h0000_0001 << ep[i]);
			chk_irq("irq enabled", 1'b1);
			bus(1'b1, 32'h0000_0310, 32'h0000_07ea);
			chk_irq("irq cleared", 1'b0);
			pulse(5'h01 << i);
			chk_irq("irq on event", 1'b1);
			bus(1'b1, 32'h0000_0310, 32'h0000_07ea);
		end
	endtask : t_events
	task automatic t_lists;
		for (int k = 0; k < 3; k++)
		begin
			bus(1'b1, 32'h0000_0314, 32'h0000_0001 << lb[k]);
			bus(1'b1, 32'h0000_0318 + 4 * k, 32'h0000_0008);
			setdm(k, 32'h0000_0008);
			chk_irq("or match", 1'b1);
			setdm(k, 32'h0000_0000);
			bus(1'b1, 32'h0000_0318 + 4 * k, 32'h0000_0000);
			bus(1'b1, 32'h0000_0310, 32'h0000_07ea);
			bus(1'b1, 32'h0000_0324 + 4 * k, 32'h0000_0003);
			setdm(k, 32'h0000_0001);
			chk_irq("and partial", 1'b0);
			setdm(k, 32'h0000_0003);
			chk_irq("and match", 1'b1);
			setdm(k, 32'h0000_0000);
			bus(1'b1, 32'h0000_0324 + 4 * k, 32'h0000_0000);
			bus(1'b1, 32'h0000_0310, 32'h0000_07ea);
		end
	endtask : t_lists
	// Watchdog against a hung handshake
	initial
	begin
		#100000;
		fails++;
		end_sim;
	end
	// Reset, then the scenarios
	initial
	begin
		rst    = 1'b1;
		hsel   = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr  = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		evs    = 5'h00;
		hsize = 3'h2;
		dm = '{default: 32'h0};
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_events;
		t_lists;
		end_sim;
	end
endmodule : testbench
`default_nettype wire
